// ### acs_exec_unit.sv
// Execution of the accumulator add and converter start instructions
//
// Operation
// - add_immediate_op adds a 0..15 immediate to the accumulator, stores it, and skips the next instruction unless it overflowed.
// - add_immediate_op never changes carry_flag, overflow or not.
// - add_memory_op adds the nibble at nibble_pointer into the accumulator, keeps carry_flag, never skips.
// - add_memory_carry_op adds accumulator, memory nibble and carry_flag, stores the sum and loads carry_flag with the carry out.
// - converter_start_op clears conversion_done_flag and, with the mode bit at zero, starts an A/D conversion.
// - with the mode bit at one, converter_start_op starts a comparator operation instead, still clearing the flag.
// - the mode bit is bit three of converter_control_reg and is read when the start executes.
// - skip_on_conversion_done_op skips when conversion_done_flag is set and converter_irq_enable_bit is zero, then clears the flag.
module acs_exec_unit
    import acs_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Instruction from the decoder
    input  wire logic             op_valid,
    input  wire acs_op_t          op_code,
    input  wire logic [NIB_W-1:0] op_imm,
    // Data memory read port
    output logic      [PTR_W-1:0] mem_addr,
    input  wire logic [NIB_W-1:0] mem_nibble,
    // Converter side
    input  wire logic             conv_complete,
    output logic                  adc_start,
    output logic                  cmp_start,
    // Results
    output logic      [NIB_W-1:0] acc,
    output logic                  carry_flag,
    output logic                  conversion_done_flag,
    output logic                  skip_next,
    output logic                  op_done,
    output logic                  irq
);

    typedef struct packed {
        logic [NIB_W-1:0] acc;
        logic             carry_flag;
        logic             done_flag;
        logic [NIB_W-1:0] conv_ctrl;
        logic [PTR_W-1:0] pointer;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic [31:0]      prdata;
        logic             pslverr;
        logic             skip_next;
        logic             adc_start;
        logic             cmp_start;
        logic             op_done;
    } acs_state_t;

    localparam acs_state_t STATE_RESET = '{
        acc:        ACC_RESET,
        carry_flag: CARRY_RESET,
        done_flag:  DONE_RESET,
        conv_ctrl:  CONV_CTRL_RESET,
        pointer:    POINTER_RESET,
        irq_status: '0,
        irq_enable: IRQ_EN_RESET,
        prdata:     '0,
        pslverr:    1'b0,
        skip_next:  1'b0,
        adc_start:  1'b0,
        cmp_start:  1'b0,
        op_done:    1'b0
    };

    acs_state_t state;
    acs_state_t next_state;

    logic [NIB_W-1:0] add_b;
    logic             add_cin;
    logic [NIB_W-1:0] add_sum;
    logic             add_cout;

    logic             setup_phase;
    logic             access_wr;
    logic             addr_hit;
    logic [31:0]      rd_value;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic             do_imm;
    logic             do_start;
    logic             skip_ok;
    logic             wr_acc;
    logic             wr_flags;
    logic             wr_ctrl;
    logic             wr_ptr;
    logic             wr_enable;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] irq_pending;

    // Operand selection; one shared adder serves all three add forms
    always_comb begin
        add_b   = mem_nibble;
        add_cin = 1'b0;
        if (op_code == ACS_OP_ADD_IMM) begin
            add_b = op_imm;
        end
        if (op_code == ACS_OP_ADD_MEM_CARRY) begin
            add_cin = state.carry_flag;
        end
    end

    acs_nibble_adder u_adder (
        .a    (state.acc),
        .b    (add_b),
        .cin  (add_cin),
        .sum  (add_sum),
        .cout (add_cout)
    );

    // Read mux; a read is decoded in the setup cycle so prdata is a flop
    always_comb begin
        rd_value = '0;
        addr_hit = 1'b1;
        case (paddr)
            ADDR_ACC: begin
                rd_value[NIB_W-1:0] = state.acc;
            end
            ADDR_FLAGS: begin
                rd_value[FLAGS_CARRY_BIT] = state.carry_flag;
                rd_value[FLAGS_DONE_BIT]  = state.done_flag;
            end
            ADDR_CONV_CTRL: begin
                rd_value[NIB_W-1:0] = state.conv_ctrl;
            end
            ADDR_POINTER: begin
                rd_value[PTR_W-1:0] = state.pointer;
            end
            ADDR_IRQ_STATUS: begin
                rd_value[IRQ_W-1:0] = state.irq_status;
            end
            ADDR_IRQ_CLEAR: begin
                rd_value = '0;
            end
            ADDR_IRQ_ENABLE: begin
                rd_value[IRQ_W-1:0] = state.irq_enable;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        setup_phase = psel && !penable;
        access_wr   = psel && penable && pwrite && addr_hit;
        irq_clear   = '0;
        if (access_wr && paddr == ADDR_IRQ_CLEAR) begin
            irq_clear = pwdata[IRQ_W-1:0];
        end
    end

    // Write strobes; the status word has none, so writes to it drop
    always_comb begin
        wr_acc    = access_wr && paddr == ADDR_ACC;
        wr_flags  = access_wr && paddr == ADDR_FLAGS;
        wr_ctrl   = access_wr && paddr == ADDR_CONV_CTRL;
        wr_ptr    = access_wr && paddr == ADDR_POINTER;
        wr_enable = access_wr && paddr == ADDR_IRQ_ENABLE;
    end

    // Instruction strobes used by the event and skip logic
    always_comb begin
        do_imm   = op_valid && op_code == ACS_OP_ADD_IMM;
        do_start = op_valid && op_code == ACS_OP_CONV_START;
        // A set enable bit hands the flag to the interrupt path instead
        skip_ok  = op_valid && op_code == ACS_OP_SKIP_ON_DONE &&
                   !state.irq_enable[IRQ_DONE_BIT] && state.done_flag;
    end

    // Events that set the sticky status bits
    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_DONE_BIT]  = conv_complete;
        irq_events[IRQ_OVF_BIT]   = do_imm && add_cout;
        irq_events[IRQ_START_BIT] = do_start;
    end

    // One sticky cell per status bit; an event beats a clear in one cycle
    for (genvar gi = 0; gi < IRQ_W; gi++) begin : g_status
        assign status_next[gi] = irq_events[gi] |
                                 (state.irq_status[gi] & ~irq_clear[gi]);
        assign irq_pending[gi] = state.irq_status[gi] &
                                 state.irq_enable[gi];
    end : g_status

    // Next-state logic
    always_comb begin
        next_state = state;

        next_state.skip_next = 1'b0;
        next_state.adc_start = 1'b0;
        next_state.cmp_start = 1'b0;
        next_state.op_done   = 1'b0;

        if (setup_phase) begin
            next_state.prdata  = pwrite ? 32'h0000_0000 : rd_value;
            next_state.pslverr = !addr_hit;
        end

        // Software writes come first so that an instruction in the
        // same cycle overrides them; the core owns acc and carry.
        if (wr_acc) begin
            next_state.acc = pwdata[NIB_W-1:0];
        end
        if (wr_flags) begin
            next_state.carry_flag = pwdata[FLAGS_CARRY_BIT];
        end
        if (wr_ctrl) begin
            next_state.conv_ctrl = pwdata[NIB_W-1:0];
        end
        if (wr_ptr) begin
            next_state.pointer = pwdata[PTR_W-1:0];
        end
        if (wr_enable) begin
            next_state.irq_enable = pwdata[IRQ_W-1:0];
        end

        if (op_valid) begin
            next_state.op_done = 1'b1;
            case (op_code)
                ACS_OP_ADD_IMM: begin
                    next_state.acc       = add_sum;
                    next_state.skip_next = !add_cout;
                    // Carry is left alone even on overflow
                    next_state.carry_flag = state.carry_flag;
                end
                ACS_OP_ADD_MEM: begin
                    next_state.acc        = add_sum;
                    next_state.carry_flag = state.carry_flag;
                end
                ACS_OP_ADD_MEM_CARRY: begin
                    next_state.acc        = add_sum;
                    next_state.carry_flag = add_cout;
                end
                ACS_OP_CONV_START: begin
                    next_state.done_flag = 1'b0;
                    // Mode bit sampled now, so a later rewrite of the
                    // control register cannot retarget this start
                    if (state.conv_ctrl[CONV_MODE_BIT]) begin
                        next_state.cmp_start = 1'b1;
                    end else begin
                        next_state.adc_start = 1'b1;
                    end
                end
                ACS_OP_SKIP_ON_DONE: begin
                    if (skip_ok) begin
                        next_state.skip_next = 1'b1;
                        next_state.done_flag = 1'b0;
                    end
                end
                default: begin
                    next_state.op_done = 1'b0;
                end
            endcase
        end

        // A completion in the clearing cycle must not be lost
        if (conv_complete) begin
            next_state.done_flag = 1'b1;
        end

        // Sticky status cells come from the per-bit loop
        next_state.irq_status = status_next;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // The access phase always completes in its first cycle
    assign pready               = psel && penable;
    assign prdata               = state.prdata;
    assign pslverr              = psel && penable && state.pslverr;
    assign mem_addr             = state.pointer;
    assign acc                  = state.acc;
    assign carry_flag           = state.carry_flag;
    assign conversion_done_flag = state.done_flag;
    assign skip_next            = state.skip_next;
    assign adc_start            = state.adc_start;
    assign cmp_start            = state.cmp_start;
    assign op_done              = state.op_done;
    assign irq                  = |irq_pending;

endmodule // acs_exec_unit

// ### acs_pkg.sv
// Constants and types shared by the accumulator add / converter start unit
package acs_pkg;

    localparam int unsigned NIB_W = 4;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned IRQ_W = 3;

    // APB byte addresses
    localparam logic [7:0] ADDR_ACC        = 8'h00;
    localparam logic [7:0] ADDR_FLAGS      = 8'h04;
    localparam logic [7:0] ADDR_CONV_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_POINTER    = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // Field positions
    localparam int unsigned FLAGS_CARRY_BIT = 0;
    localparam int unsigned FLAGS_DONE_BIT  = 1;
    localparam int unsigned CONV_MODE_BIT   = 3;
    localparam int unsigned IRQ_DONE_BIT    = 0;
    localparam int unsigned IRQ_OVF_BIT     = 1;
    localparam int unsigned IRQ_START_BIT   = 2;

    // Reset values
    localparam logic [NIB_W-1:0] ACC_RESET       = 4'h0;
    localparam logic [NIB_W-1:0] CONV_CTRL_RESET = 4'h0;
    localparam logic [PTR_W-1:0] POINTER_RESET   = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET    = 3'h0;
    localparam logic             CARRY_RESET     = 1'b0;
    localparam logic             DONE_RESET      = 1'b0;

    typedef enum logic [2:0] {
        ACS_OP_ADD_IMM,
        ACS_OP_ADD_MEM,
        ACS_OP_ADD_MEM_CARRY,
        ACS_OP_CONV_START,
        ACS_OP_SKIP_ON_DONE
    } acs_op_t;

endpackage

// ### acs_nibble_adder.sv
// Four-bit adder with carry in and carry out
module acs_nibble_adder
    import acs_pkg::*;
(
    input  wire logic [NIB_W-1:0] a,
    input  wire logic [NIB_W-1:0] b,
    input  wire logic             cin,
    output logic      [NIB_W-1:0] sum,
    output logic                  cout
);

    logic [NIB_W:0] wide;

    always_comb begin
        wide = {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, cin};
        sum  = wide[NIB_W-1:0];
        cout = wide[NIB_W];
    end

endmodule // acs_nibble_adder

// ### acs_exec_monitor.sv
// Port-level assertions for the exec unit
module acs_exec_monitor
    import acs_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic             op_valid,
    input wire acs_op_t          op_code,
    input wire logic [NIB_W-1:0] op_imm,
    input wire logic [NIB_W-1:0] mem_nibble,
    input wire logic             conv_complete,
    input wire logic [NIB_W-1:0] acc,
    input wire logic             carry_flag,
    input wire logic             conversion_done_flag,
    input wire logic             skip_next,
    input wire logic             op_done,
    input wire logic             adc_start,
    input wire logic             cmp_start
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence imm_s;
        op_valid && op_code == ACS_OP_ADD_IMM;
    endsequence
    sequence mem_s;
        op_valid && op_code == ACS_OP_ADD_MEM;
    endsequence
    sequence amc_s;
        op_valid && op_code == ACS_OP_ADD_MEM_CARRY;
    endsequence
    sequence start_s;
        op_valid && op_code == ACS_OP_CONV_START;
    endsequence

    imm_sum_a: assert property (
        imm_s |=> acc == 4'($past(acc) + $past(op_imm)))
        else $error("add immediate sum wrong");
    imm_skip_a: assert property (imm_s |=> skip_next ==
        ({1'b0, $past(acc)} + {1'b0, $past(op_imm)} < 5'h10))
        else $error("add immediate skip wrong");
    imm_carry_a: assert property (imm_s |=> $stable(carry_flag))
        else $error("add immediate touched carry");
    mem_add_a: assert property (mem_s |=> !skip_next &&
        $stable(carry_flag) && acc == 4'($past(acc) + $past(mem_nibble)))
        else $error("add memory wrong");
    amc_sum_a: assert property (amc_s |=> {carry_flag, acc} ==
        5'({1'b0, $past(acc)} + $past(mem_nibble) + $past(carry_flag)))
        else $error("add memory with carry wrong");
    start_clear_a: assert property (start_s |=>
        !conversion_done_flag || $past(conv_complete))
        else $error("start left done flag set");
    start_one_a: assert property (start_s |=> adc_start ^ cmp_start)
        else $error("start pulse count wrong");
    op_done_a: assert property (op_valid |=> op_done)
        else $error("instruction not done in one cycle");
endmodule // acs_exec_monitor

// ### acs_exec_unit_test.sv
// Self-checking bench for the exec unit
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module acs_exec_unit_test
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, mem_addr;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, se, op_valid = 0, conv_complete = 0;
    logic        adc_start, cmp_start, carry_flag, conversion_done_flag;
    logic        skip_next, op_done, irq;
    acs_op_t     op_code = ACS_OP_ADD_IMM;
    logic [3:0]  op_imm = 4'h0, mem_nibble = 4'h0, acc;
    int          err_total = 0, cmp_count = 0, cyc = 0;

    acs_exec_unit dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .op_imm,
        .mem_addr, .mem_nibble, .conv_complete, .adc_start, .cmp_start,
        .acc, .carry_flag, .conversion_done_flag, .skip_next, .op_done, .irq);

    always #5 sys_clk = ~sys_clk;
    // Whole run needs about 110 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic op(input acs_op_t c, input logic [3:0] n, m, input logic p);
        @(posedge sys_clk);
        op_valid <= !p;
        conv_complete <= p;
        op_code <= c;
        op_imm <= n;
        mem_nibble <= m;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        conv_complete <= 1'b0;
        #1;
    endtask

    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("reset reg", 32'h0, rd)
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, se)
    endtask

    task automatic t_imm();
        logic [4:0] s;
        logic [3:0] av[5] = '{4'h9, 4'h1, 4'hf, 4'h0, 4'hf};
        logic [3:0] nv[5] = '{4'h8, 4'h2, 4'h0, 4'hf, 4'h1};
        apb(1'b1, ADDR_FLAGS, 32'h1);
        for (int i = 0; i < 5; i++) begin
            s = {1'b0, av[i]} + {1'b0, nv[i]};
            apb(1'b1, ADDR_ACC, 32'(av[i]));
            op(ACS_OP_ADD_IMM, nv[i], 4'h0, 1'b0);
            `CHK("imm sum", s[3:0], acc)
            `CHK("imm skip", ~s[4], skip_next)
            `CHK("imm carry", 1'b1, carry_flag)
            `CHK("op done", 1'b1, op_done)
        end
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("ovf status", 1'b1, rd[IRQ_OVF_BIT])
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h2);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("ovf clear", 1'b0, rd[IRQ_OVF_BIT])
    endtask

    task automatic t_mem();
        logic [4:0] s;
        logic [3:0] mv[4] = '{4'h7, 4'h7, 4'h0, 4'hf};
        logic [3:0] a = 4'h4;
        logic       c = 1'b1;
        apb(1'b1, ADDR_POINTER, 32'h5a);
        `CHK("mem addr", 8'h5a, mem_addr)
        apb(1'b1, ADDR_ACC, 32'h4);
        for (int i = 0; i < 4; i++) begin
            s = {1'b0, a} + {1'b0, mv[i]} + 5'(i > 0 && c);
            op(i == 0 ? ACS_OP_ADD_MEM : ACS_OP_ADD_MEM_CARRY, 4'h0, mv[i], 1'b0);
            // First pass must keep carry although no carry out appears
            c = (i > 0) ? s[4] : c;
            a = s[3:0];
            `CHK("mem acc", a, acc)
            `CHK("mem carry", c, carry_flag)
            `CHK("mem skip", 1'b0, skip_next)
        end
    endtask

    task automatic t_conv();
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, ADDR_CONV_CTRL, 32'(m * 8));
            op(ACS_OP_CONV_START, 4'h0, 4'h0, 1'b1);
            `CHK("done set", 1'b1, conversion_done_flag)
            op(ACS_OP_CONV_START, 4'h0, 4'h0, 1'b0);
            `CHK("done clr", 1'b0, conversion_done_flag)
            `CHK("adc start", m == 0, adc_start)
            `CHK("cmp start", m == 1, cmp_start)
        end
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        `CHK("irq quiet", 1'b0, irq)
        op(ACS_OP_CONV_START, 4'h0, 4'h0, 1'b1);
        `CHK("irq on", 1'b1, irq)
        op(ACS_OP_SKIP_ON_DONE, 4'h0, 4'h0, 1'b0);
        `CHK("no skip", 1'b0, skip_next)
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        `CHK("irq off", 1'b0, irq)
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        op(ACS_OP_CONV_START, 4'h0, 4'h0, 1'b1);
        `CHK("irq mask", 1'b0, irq)
        op(ACS_OP_SKIP_ON_DONE, 4'h0, 4'h0, 1'b0);
        `CHK("skip", 1'b1, skip_next)
        `CHK("skip clr", 1'b0, conversion_done_flag)
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_imm();
        t_mem();
        t_conv();
        end_of_test();
    end
endmodule // acs_exec_unit_test

bind acs_exec_unit acs_exec_monitor mon (.sys_clk, .rst, .op_valid, .op_code,
    .op_imm, .mem_nibble, .conv_complete, .acc, .carry_flag,
    .conversion_done_flag, .skip_next, .op_done, .adc_start, .cmp_start);
